// [include/plar_pkg.sv]
// Shared constants, enumerations and carriers for the pattern and loop-code block
package plar_pkg;
   // Timebase
   localparam int CLK_HZ = 40_000_000;
   localparam int MS_PER_S = 1000;
   localparam int TICK_CYC = CLK_HZ / MS_PER_S;
   // Loop-up qualification times in milliseconds
   localparam int INB_UP_MS = 5000;
   localparam int OOB_UP_MS = 250;
   localparam int MS_W = 13;
   // Pattern storage
   localparam int PAT_W = 24;
   localparam int LOOP_W = 8;
   localparam int LEN_W = 5;
   localparam int PAT_MIN = 3;
   localparam int NTGT = 4;
   localparam logic [PAT_W-1:0] PAT1_RST = 24'h00004A;
   localparam logic [PAT_W-1:0] PAT2_RST = 24'h0000EC;
   localparam logic [PAT_W-1:0] PAT3_RST = 24'h0000E3;
   localparam logic [PAT_W-1:0] LOOP_RST = 24'h000001;
   localparam logic [NTGT-1:0][PAT_W-1:0] PAT_RST = {LOOP_RST, PAT3_RST, PAT2_RST, PAT1_RST};
   localparam logic [NTGT-1:0][LEN_W-1:0] LEN_RST = {5'h05, 5'h09, 5'h09, 5'h09};
   // Sequence durations: codes 0..4 are 15 s steps, 5..18 are whole minutes 2..15
   localparam int NCOMP = 5;
   localparam int DUR_W = 5;
   localparam int DUR_STEP_S = 15;
   localparam int DUR_MIN_S = 60;
   localparam int DUR_FINE_MAX = 4;
   localparam int SEC_W = 10;

   typedef enum logic [1:0] {TGT_PAT1 = 2'h0, TGT_PAT2 = 2'h1, TGT_PAT3 = 2'h2, TGT_LOOP = 2'h3} plar_tgt_t;
   typedef enum logic [2:0] {CMD_NONE = 3'h0, CMD_FWD = 3'h1, CMD_REV = 3'h2, CMD_TOGGLE = 3'h3,
                             CMD_END = 3'h4} plar_cmd_t;
   typedef enum logic [2:0] {P_PAT1 = 3'h0, P_PAT2 = 3'h1, P_PAT3 = 3'h2, P_SEQ = 3'h3, P_OCT55 = 3'h4,
                             P_3IN24 = 3'h5, P_OTHER = 3'h6} plar_psel_t;
   typedef enum logic [2:0] {MD_T1 = 3'h0, MD_D4 = 3'h1, MD_D1D = 3'h2, MD_CARRIER = 3'h3, MD_ESF = 3'h4,
                             MD_TERM_LB = 3'h5, MD_LINE_LB = 3'h6, MD_AUTO_LB = 3'h7} plar_mode_t;
   typedef enum logic [1:0] {LSRC_CHANNEL = 2'h0, LSRC_NETWORK = 2'h1, LSRC_PROGRAMMABLE = 2'h2} plar_lsrc_t;
   typedef enum logic [1:0] {CH_IN_BAND = 2'h0, CH_ESF_LINE = 2'h1, CH_ESF_PAYLOAD = 2'h2} plar_ch_t;
   typedef enum logic [1:0] {NI_FAC1 = 2'h0, NI_FAC2 = 2'h1, NI_FAC3 = 2'h2, NI_ESF_NET = 2'h3} plar_ni_t;
   typedef enum logic [2:0] {C_NONE = 3'h0, C_CH_INB = 3'h1, C_ESF_LINE = 3'h2, C_FAC1 = 3'h3, C_FAC2 = 3'h4,
                             C_FAC3 = 3'h5, C_ESF_NET = 3'h6, C_USER = 3'h7} plar_code_t;
   typedef enum logic [2:0] {CP_ONES = 3'h0, CP_1IN8 = 3'h1, CP_2IN8 = 3'h2, CP_3IN24 = 3'h3,
                             CP_QRSS = 3'h4} plar_comp_t;
   typedef enum logic {AR_IDLE = 1'b0, AR_LOOP = 1'b1} plar_ar_t;

   typedef struct packed {
      plar_tgt_t tgt;
      plar_cmd_t cmd;
   } plar_edit_t;
   typedef struct packed {
      plar_code_t code;
      logic inb_up;
      logic inb_dn;
      logic oob_up;
      logic oob_dn;
   } plar_rx_t;
   typedef struct packed {
      logic cur;
      logic hist;
   } plar_dens_t;
   typedef logic [NCOMP-1:0][DUR_W-1:0] plar_durs_t;
endpackage : plar_pkg

// [rtl/plar_core.sv]
// User patterns, timed pattern sequence, density masking and automatic loop response
`timescale 1ns/1ps
module plar_core #(
   parameter int TICK_CYC_P = plar_pkg::TICK_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Front panel settings
   input wire plar_pkg::plar_edit_t edit_i,
   input wire plar_pkg::plar_psel_t pat_sel_i,
   input wire plar_pkg::plar_durs_t sequence_durations,
   input wire logic auto_loop_response,
   input wire logic octet_fifty_five_alarm_en,
   input wire logic three_in_24_alarm_en,
   input wire plar_pkg::plar_mode_t op_mode_i,
   input wire plar_pkg::plar_lsrc_t loop_src_i,
   input wire plar_pkg::plar_ch_t channel_unit_loop_select,
   input wire plar_pkg::plar_ni_t network_interface_loop_select,
   input wire logic loop_up_req,
   // Line side
   input wire logic bit_en,
   input wire logic rx_bit,
   input wire logic rx_bit_en,
   input wire plar_pkg::plar_rx_t rx_det,
   input wire logic pat_sync,
   input wire plar_pkg::plar_dens_t dens_raw,
   // Transmit
   output logic tx_bit,
   output logic tx_bit_vld,
   output logic tx_loop_inband,
   output logic dl_loop_req,
   // Status
   output plar_pkg::plar_comp_t seq_comp,
   output logic seq_on,
   output plar_pkg::plar_dens_t dens_out,
   output logic automatic_line_loopback,
   output plar_pkg::plar_mode_t eff_mode,
   output logic [plar_pkg::LEN_W-1:0] cursor
);
   import plar_pkg::*;

   function automatic logic [LEN_W-1:0] tgt_max(input int e);
      tgt_max = (e == int'(TGT_LOOP)) ? LEN_W'(LOOP_W) : LEN_W'(PAT_W);
   endfunction : tgt_max

   function automatic logic [SEC_W-1:0] dur_sec(input logic [DUR_W-1:0] c);
      if (c <= DUR_W'(DUR_FINE_MAX))
         dur_sec = SEC_W'(c * DUR_STEP_S);
      else
         dur_sec = SEC_W'((c - 5'h03) * DUR_MIN_S);
   endfunction : dur_sec

   // Millisecond tick
   logic [15:0] tick_cnt_r;
   logic ms_tick;
   assign ms_tick = (tick_cnt_r == 16'(TICK_CYC_P - 1));
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         tick_cnt_r <= '0;
      else
         tick_cnt_r <= ms_tick ? '0 : tick_cnt_r + 16'h0001;
   end

   // Pattern editing
   logic [PAT_W-1:0] pat_w [NTGT];
   logic [LEN_W-1:0] len_w [NTGT];
   logic [LEN_W-1:0] cur_r;
   plar_tgt_t tgt_q_r;
   logic same_tgt;
   logic [LEN_W-1:0] cur_max;
   assign same_tgt = (edit_i.tgt == tgt_q_r);
   assign cur_max = tgt_max(int'(edit_i.tgt));
   assign cursor = cur_r;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cur_r <= '0;
         tgt_q_r <= TGT_PAT1;
      end else begin
         tgt_q_r <= edit_i.tgt;
         if (!same_tgt)
            cur_r <= '0;
         else if (edit_i.cmd == CMD_FWD && cur_r < cur_max - 5'h01)
            cur_r <= cur_r + 5'h01;
         else if (edit_i.cmd == CMD_REV && cur_r != '0)
            cur_r <= cur_r - 5'h01;
      end
   end

   genvar e;
   generate
      for (e = 0; e < NTGT; e++) begin : g_store
         logic [PAT_W-1:0] p_r;
         logic [LEN_W-1:0] l_r;
         logic hit;
         assign hit = same_tgt && (edit_i.tgt == plar_tgt_t'(e));
         assign pat_w[e] = p_r;
         assign len_w[e] = l_r;
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               p_r <= PAT_RST[e];
               l_r <= LEN_RST[e];
            end else if (hit) begin
               unique case (edit_i.cmd)
                  CMD_NONE, CMD_REV: ;
                  // Moving past the end shows a new bit
                  CMD_FWD: if (cur_r < tgt_max(e) - 5'h01 && cur_r + 5'h01 >= l_r) begin
                     l_r <= cur_r + 5'h02;
                  end
                  CMD_TOGGLE: p_r[cur_r] <= ~p_r[cur_r];
                  CMD_END: begin
                     l_r <= (cur_r < LEN_W'(PAT_MIN - 1)) ? LEN_W'(PAT_MIN) : cur_r + 5'h01;
                     p_r <= p_r & ~({PAT_W{1'b1}} << (cur_r + 5'h01));
                  end
                  default: ;
               endcase
            end
         end
      end
   endgenerate

   // Transmit source
   logic esf;
   logic framed;
   logic loop_tx;
   logic loop_oob;
   logic user_sel;
   logic [1:0] src;
   logic [1:0] src_q_r;
   logic run_q_r;
   logic ser_run;
   assign esf = (op_mode_i == MD_ESF);
   assign framed = (op_mode_i != MD_T1);
   assign loop_tx = loop_up_req && (loop_src_i == LSRC_PROGRAMMABLE);
   assign loop_oob = esf && (channel_unit_loop_select != CH_IN_BAND);
   assign user_sel = (pat_sel_i == P_PAT1) || (pat_sel_i == P_PAT2) || (pat_sel_i == P_PAT3);
   assign src = loop_tx ? 2'(TGT_LOOP) : pat_sel_i[1:0];
   assign ser_run = loop_tx || user_sel;
   assign tx_loop_inband = loop_tx && !loop_oob;
   assign dl_loop_req = loop_tx && loop_oob;

   // A source change restarts at the leftmost bit
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         src_q_r <= '0;
         run_q_r <= 1'b0;
      end else begin
         src_q_r <= src;
         run_q_r <= ser_run;
      end
   end

   plar_ser u_ser (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .bits(pat_w[src]),
      .len(len_w[src]),
      .run(ser_run),
      .restart(src != src_q_r || !run_q_r),
      .bit_en(bit_en),
      .ser_bit(tx_bit),
      .ser_vld(tx_bit_vld)
   );

   // Timed pattern sequence
   plar_comp_t seq_idx_r;
   logic [SEC_W-1:0] sec_cnt_r;
   logic [SEC_W-1:0] ms_in_s_r;
   logic [SEC_W-1:0] cur_dur;
   logic seq_run;
   logic skip;
   logic sec_tick;
   logic adv;
   assign seq_run = (pat_sel_i == P_SEQ);
   assign cur_dur = dur_sec(sequence_durations[seq_idx_r]);
   assign skip = (cur_dur == '0);
   assign sec_tick = ms_tick && (ms_in_s_r == SEC_W'(MS_PER_S - 1));
   // skip zero; each for its time
   assign adv = skip || (sec_tick && sec_cnt_r == cur_dur - 10'h001);
   assign seq_on = seq_run && !skip;
   assign seq_comp = seq_idx_r;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_idx_r <= CP_ONES;
         sec_cnt_r <= '0;
         ms_in_s_r <= '0;
      end else if (!seq_run) begin
         seq_idx_r <= CP_ONES;
         sec_cnt_r <= '0;
         ms_in_s_r <= '0;
      end else if (adv) begin
         seq_idx_r <= (seq_idx_r == CP_QRSS) ? CP_ONES : plar_comp_t'(seq_idx_r + 3'h1);
         sec_cnt_r <= '0;
         ms_in_s_r <= '0;
      end else if (ms_tick) begin
         ms_in_s_r <= sec_tick ? '0 : ms_in_s_r + 10'h001;
         if (sec_tick)
            sec_cnt_r <= sec_cnt_r + 10'h001;
      end
   end

   // Ones-density masking
   logic dens_en;
   logic dens_sup;
   assign dens_en = (pat_sel_i == P_OCT55) ? octet_fifty_five_alarm_en :
                    (pat_sel_i == P_3IN24) ? three_in_24_alarm_en : 1'b1;
   assign dens_sup = framed && !dens_en && pat_sync;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         dens_out <= '0;
      else
         dens_out <= dens_sup ? '0 : dens_raw;
   end

   // Received programmable loop-up code: periodic and aligned once
   logic [LOOP_W-1:0] rx_hist_r;
   logic user_seen_r;
   logic win_ok;
   logic per_ok;
   logic [LEN_W-1:0] ul;
   assign ul = len_w[TGT_LOOP];
   assign per_ok = (rx_bit == rx_hist_r[3'(ul - 5'h01)]);
   always_comb begin
      win_ok = 1'b1;
      for (int j = 0; j < LOOP_W; j++)
         if (j < int'(ul) && rx_hist_r[j] != pat_w[TGT_LOOP][5'(int'(ul) - 1 - j)])
            win_ok = 1'b0;
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_hist_r <= '0;
         user_seen_r <= 1'b0;
      end else if (rx_bit_en) begin
         rx_hist_r <= {rx_hist_r[LOOP_W-2:0], rx_bit};
         if (!per_ok)
            user_seen_r <= 1'b0;
         else if (win_ok)
            user_seen_r <= 1'b1;
      end
   end

   // Selected response code
   plar_code_t sel_code;
   always_comb begin
      sel_code = C_NONE;
      unique case (loop_src_i)
         LSRC_CHANNEL: begin
            if (channel_unit_loop_select == CH_IN_BAND)
               sel_code = C_CH_INB;
            else if (channel_unit_loop_select == CH_ESF_LINE)
               sel_code = esf ? C_ESF_LINE : C_CH_INB;
         end
         LSRC_NETWORK: begin
            unique case (network_interface_loop_select)
               NI_FAC1: sel_code = C_FAC1;
               NI_FAC2: sel_code = C_FAC2;
               NI_FAC3: sel_code = C_FAC3;
               NI_ESF_NET: sel_code = esf ? C_ESF_NET : C_FAC2;
            endcase
         end
         LSRC_PROGRAMMABLE: sel_code = C_USER;
         default: sel_code = C_NONE;
      endcase
   end

   // Automatic loopback control
   plar_ar_t ar_st_r;
   plar_ar_t ar_nxt;
   plar_mode_t mode_r;
   logic [MS_W-1:0] up_cnt_r;
   logic [MS_W-1:0] up_thr;
   logic armed;
   logic match;
   logic up_inb;
   logic up_oob;
   logic dn_hit;
   assign armed = auto_loop_response && op_mode_i != MD_TERM_LB && op_mode_i != MD_LINE_LB;
   assign match = (sel_code != C_NONE) && (rx_det.code == sel_code);
   assign up_inb = armed && ((sel_code == C_USER) ? user_seen_r : (match && rx_det.inb_up));
   assign up_oob = armed && match && rx_det.oob_up;
   assign dn_hit = armed && match && (rx_det.inb_dn || rx_det.oob_dn);
   assign up_thr = up_oob ? MS_W'(OOB_UP_MS) : MS_W'(INB_UP_MS);
   assign automatic_line_loopback = (ar_st_r == AR_LOOP);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         up_cnt_r <= '0;
      else if (ar_st_r != AR_IDLE || !(up_inb || up_oob))
         up_cnt_r <= '0;
      else if (ms_tick && up_cnt_r < up_thr)
         up_cnt_r <= up_cnt_r + 13'h0001;
   end

   always_comb begin
      ar_nxt = ar_st_r;
      unique case (ar_st_r)
         AR_IDLE: if ((up_inb || up_oob) && up_cnt_r >= up_thr) ar_nxt = AR_LOOP;
         AR_LOOP: if (dn_hit) ar_nxt = AR_IDLE;
      endcase
   end

   // mode held while looped, restored on exit
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ar_st_r <= AR_IDLE;
         mode_r <= MD_T1;
         eff_mode <= MD_T1;
      end else begin
         ar_st_r <= ar_nxt;
         if (ar_st_r == AR_IDLE)
            mode_r <= op_mode_i;
         eff_mode <= (ar_nxt == AR_LOOP) ? MD_AUTO_LB : ((ar_st_r == AR_LOOP) ? mode_r : op_mode_i);
      end
   end

   property p_skip;
      @(posedge core_clk) disable iff (!rst_b)
      (seq_run && skip) |=> (seq_idx_r != $past(seq_idx_r));
   endproperty
   a_skip: assert property (p_skip) else $error("zero-duration component not skipped");

   property p_dens_on;
      @(posedge core_clk) disable iff (!rst_b)
      (framed && dens_en) |=> (dens_out == $past(dens_raw));
   endproperty
   a_dens_on: assert property (p_dens_on) else $error("enabled density alarm altered");

   property p_dens_off;
      @(posedge core_clk) disable iff (!rst_b)
      (framed && !dens_en && pat_sync) |=> (dens_out == '0);
   endproperty
   a_dens_off: assert property (p_dens_off) else $error("disabled density alarm not masked");

   property p_noresp;
      @(posedge core_clk) disable iff (!rst_b)
      (!auto_loop_response && ar_st_r == AR_IDLE) |=> (ar_st_r == AR_IDLE);
   endproperty
   a_noresp: assert property (p_noresp) else $error("loopback entered with response off");

   property p_other_code;
      @(posedge core_clk) disable iff (!rst_b)
      (ar_st_r == AR_IDLE && sel_code != C_USER && rx_det.code != sel_code) |=> (up_cnt_r == '0);
   endproperty
   a_other_code: assert property (p_other_code) else $error("unselected code was timed");

   property p_manual;
      @(posedge core_clk) disable iff (!rst_b)
      (ar_st_r == AR_IDLE && (op_mode_i == MD_TERM_LB || op_mode_i == MD_LINE_LB)) |=> (ar_st_r == AR_IDLE);
   endproperty
   a_manual: assert property (p_manual) else $error("loopback entered from manual mode");

   property p_inb_early;
      @(posedge core_clk) disable iff (!rst_b)
      (ar_st_r == AR_IDLE && up_inb && !up_oob && up_cnt_r < MS_W'(INB_UP_MS)) |=> (ar_st_r == AR_IDLE);
   endproperty
   a_inb_early: assert property (p_inb_early) else $error("in-band loop-up accepted too soon");

   property p_oob_enter;
      @(posedge core_clk) disable iff (!rst_b)
      (ar_st_r == AR_IDLE && up_oob && up_cnt_r >= MS_W'(OOB_UP_MS)) |=> (ar_st_r == AR_LOOP);
   endproperty
   a_oob_enter: assert property (p_oob_enter) else $error("data-link loop-up not accepted");

   property p_exit;
      @(posedge core_clk) disable iff (!rst_b)
      (ar_st_r == AR_LOOP && dn_hit) |=> (ar_st_r == AR_IDLE && !automatic_line_loopback);
   endproperty
   a_exit: assert property (p_exit) else $error("loop-down did not release loopback");

   property p_restore;
      @(posedge core_clk) disable iff (!rst_b)
      (ar_st_r == AR_LOOP && ar_nxt == AR_IDLE) |=> (eff_mode == $past(mode_r));
   endproperty
   a_restore: assert property (p_restore) else $error("previous mode not restored");

   c_enter: cover property (@(posedge core_clk) disable iff (!rst_b) ar_st_r == AR_IDLE ##1 ar_st_r == AR_LOOP);
   c_exit: cover property (@(posedge core_clk) disable iff (!rst_b) ar_st_r == AR_LOOP ##1 ar_st_r == AR_IDLE);
   c_seq_wrap: cover property (@(posedge core_clk) disable iff (!rst_b) seq_idx_r == CP_QRSS ##1 seq_idx_r == CP_ONES);
   c_end: cover property (@(posedge core_clk) disable iff (!rst_b) same_tgt && edit_i.cmd == CMD_END);
endmodule : plar_core

// [rtl/plar_ser.sv]
// Circular bit serializer for stored patterns and loop codes
`timescale 1ns/1ps
module plar_ser (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Source
   input wire logic [plar_pkg::PAT_W-1:0] bits,
   input wire logic [plar_pkg::LEN_W-1:0] len,
   input wire logic run,
   input wire logic restart,
   input wire logic bit_en,
   // Serial out
   output logic ser_bit,
   output logic ser_vld
);
   import plar_pkg::*;

   logic [LEN_W-1:0] idx_r;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         idx_r <= '0;
         ser_bit <= 1'b0;
         ser_vld <= 1'b0;
      end else if (!run || restart) begin
         idx_r <= '0;
         ser_vld <= 1'b0;
      end else if (bit_en) begin
         ser_bit <= bits[idx_r];
         ser_vld <= 1'b1;
         idx_r <= (idx_r >= len - 5'h01) ? '0 : idx_r + 5'h01;
      end
   end

   property p_order;
      @(posedge core_clk) disable iff (!rst_b)
      (run && !restart && bit_en) |=> (ser_bit == $past(bits[idx_r]));
   endproperty
   a_order: assert property (p_order) else $error("serial bit not taken from current index");

   property p_wrap;
      @(posedge core_clk) disable iff (!rst_b)
      (run && !restart && bit_en && idx_r == len - 5'h01) |=> (idx_r == '0);
   endproperty
   a_wrap: assert property (p_wrap) else $error("pattern did not wrap to first bit");
endmodule : plar_ser

// [tb/plar_core_tb.sv]
// Self-checking bench for the pattern and loop-code block
`timescale 1ns/1ps
module plar_core_tb;
   import plar_pkg::*;
   localparam int TK = 2;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   plar_edit_t edit_i = '0;
   plar_psel_t pat_sel_i = P_OTHER;
   plar_durs_t sequence_durations = '0;
   logic auto_loop_response = 1'b0;
   logic octet_fifty_five_alarm_en = 1'b0;
   logic three_in_24_alarm_en = 1'b0;
   plar_mode_t op_mode_i = MD_T1;
   plar_lsrc_t loop_src_i = LSRC_CHANNEL;
   plar_ch_t channel_unit_loop_select = CH_IN_BAND;
   plar_ni_t network_interface_loop_select = NI_FAC1;
   logic loop_up_req = 1'b0;
   logic bit_en = 1'b0;
   logic pat_sync = 1'b0;
   plar_dens_t dens_raw = '0;
   plar_code_t f_code = C_NONE;
   logic f_oob = 1'b0;
   logic f_up = 1'b0;
   logic f_dn = 1'b0;
   logic rx_bit, rx_bit_en, tx_bit, tx_bit_vld, tx_loop_inband, dl_loop_req, seq_on, automatic_line_loopback;
   plar_rx_t rx_det;
   plar_comp_t seq_comp;
   plar_dens_t dens_out;
   plar_mode_t eff_mode;
   logic [LEN_W-1:0] cursor;
   logic [2:0][8:0] dflt = {9'h18E, 9'h06E, 9'h0A4};
   int n_fail = 0;
   int n_checks = 0;

   always #12.5 core_clk = ~core_clk;

   plar_core #(.TICK_CYC_P(TK)) plar_core_inst (.core_clk, .rst_b, .edit_i, .pat_sel_i, .sequence_durations,
      .auto_loop_response, .octet_fifty_five_alarm_en, .three_in_24_alarm_en, .op_mode_i, .loop_src_i,
      .channel_unit_loop_select, .network_interface_loop_select, .loop_up_req, .bit_en, .rx_bit, .rx_bit_en,
      .rx_det, .pat_sync, .dens_raw, .tx_bit, .tx_bit_vld, .tx_loop_inband, .dl_loop_req, .seq_comp, .seq_on,
      .dens_out, .automatic_line_loopback, .eff_mode, .cursor);
   plar_far_end plar_far_end_inst (.core_clk, .code(f_code), .oob(f_oob), .up(f_up), .dn(f_dn), .pgm(5'h18), .rx_det,
      .rx_bit, .rx_bit_en);

   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   // One press is exactly one cycle of command
   task automatic ed(input plar_cmd_t c);
      @(posedge core_clk);
      edit_i.cmd <= c;
      @(posedge core_clk);
      edit_i.cmd <= CMD_NONE;
   endtask : ed
   task automatic bits(input logic [23:0] exp, input int len, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         bit_en <= 1'b1;
         @(posedge core_clk);
         bit_en <= 1'b0;
         #1;
         chk("tx bit", tx_bit, exp[len-1-(i%len)]);
      end
   endtask : bits
   task automatic far(input plar_code_t c, input logic o, input logic u, input logic d, input int ms);
      @(posedge core_clk);
      f_code <= c;
      f_oob <= o;
      f_up <= u;
      f_dn <= d;
      cyc(ms * TK);
   endtask : far
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      for (int p = 0; p < 3; p++) begin
         @(posedge core_clk);
         pat_sel_i <= plar_psel_t'(p);
         cyc(3);
         bits(24'(dflt[p]), 9, 12);
         chk("valid", tx_bit_vld, 24'h1);
      end
      @(posedge core_clk);
      pat_sel_i <= P_OTHER;
      ed(CMD_FWD);
      ed(CMD_FWD);
      ed(CMD_REV);
      cyc(2);
      chk("cursor", cursor, 24'h1);
      ed(CMD_REV);
      ed(CMD_REV);
      ed(CMD_TOGGLE);
      ed(CMD_END);
      @(posedge core_clk);
      pat_sel_i <= P_PAT1;
      cyc(3);
      bits(24'h4, 3, 6);
      @(posedge core_clk);
      edit_i.tgt <= TGT_LOOP;
      pat_sel_i <= P_OTHER;
      cyc(2);
      ed(CMD_FWD);
      ed(CMD_TOGGLE);
      @(posedge core_clk);
      op_mode_i <= MD_D4;
      loop_src_i <= LSRC_PROGRAMMABLE;
      loop_up_req <= 1'b1;
      cyc(3);
      chk("band", {tx_loop_inband, dl_loop_req}, 24'h2);
      bits(24'h18, 5, 10);
      @(posedge core_clk);
      op_mode_i <= MD_ESF;
      channel_unit_loop_select <= CH_ESF_LINE;
      cyc(2);
      chk("band", {tx_loop_inband, dl_loop_req}, 24'h1);
      @(posedge core_clk);
      channel_unit_loop_select <= CH_IN_BAND;
      cyc(2);
      chk("band", {tx_loop_inband, dl_loop_req}, 24'h2);
      @(posedge core_clk);
      loop_up_req <= 1'b0;
      loop_src_i <= LSRC_CHANNEL;
      op_mode_i <= MD_D4;
      dens_raw <= 2'h3;
      pat_sync <= 1'b1;
      pat_sel_i <= P_OCT55;
      three_in_24_alarm_en <= 1'b1;
      cyc(3);
      chk("density", dens_out, 24'h0);
      @(posedge core_clk);
      pat_sel_i <= P_3IN24;
      cyc(3);
      chk("density", dens_out, 24'h3);
      @(posedge core_clk);
      pat_sel_i <= P_OCT55;
      pat_sync <= 1'b0;
      cyc(3);
      chk("density", dens_out, 24'h3);
      @(posedge core_clk);
      op_mode_i <= MD_ESF;
      channel_unit_loop_select <= CH_ESF_LINE;
      far(C_ESF_LINE, 1'b1, 1'b1, 1'b0, 300);
      chk("loopback", automatic_line_loopback, 24'h0);
      far(C_NONE, 1'b0, 1'b0, 1'b0, 1);
      @(posedge core_clk);
      auto_loop_response <= 1'b1;
      op_mode_i <= MD_TERM_LB;
      far(C_ESF_LINE, 1'b1, 1'b1, 1'b0, 300);
      chk("loopback", automatic_line_loopback, 24'h0);
      far(C_NONE, 1'b0, 1'b0, 1'b0, 1);
      @(posedge core_clk);
      op_mode_i <= MD_ESF;
      far(C_ESF_NET, 1'b1, 1'b1, 1'b0, 300);
      chk("loopback", automatic_line_loopback, 24'h0);
      far(C_ESF_LINE, 1'b1, 1'b1, 1'b0, 240);
      chk("loopback", automatic_line_loopback, 24'h0);
      cyc(20 * TK);
      chk("mode", eff_mode, MD_AUTO_LB);
      far(C_ESF_LINE, 1'b1, 1'b0, 1'b1, 1);
      chk("mode", eff_mode, MD_ESF);
      far(C_NONE, 1'b0, 1'b0, 1'b0, 1);
      @(posedge core_clk);
      op_mode_i <= MD_D4;
      channel_unit_loop_select <= CH_IN_BAND;
      far(C_CH_INB, 1'b0, 1'b1, 1'b0, 4950);
      chk("loopback", automatic_line_loopback, 24'h0);
      cyc(100 * TK);
      chk("loopback", automatic_line_loopback, 24'h1);
      far(C_CH_INB, 1'b0, 1'b0, 1'b1, 1);
      chk("mode", eff_mode, MD_D4);
      @(posedge core_clk);
      loop_src_i <= LSRC_PROGRAMMABLE;
      far(C_USER, 1'b0, 1'b1, 1'b0, 4900);
      chk("loopback", automatic_line_loopback, 24'h0);
      cyc(200 * TK);
      chk("loopback", automatic_line_loopback, 24'h1);
      far(C_USER, 1'b0, 1'b0, 1'b1, 1);
      chk("mode", eff_mode, MD_D4);
      @(posedge core_clk);
      loop_src_i <= LSRC_CHANNEL;
      @(posedge core_clk);
      sequence_durations <= {5'h00, 5'h01, 5'h00, 5'h01, 5'h00};
      pat_sel_i <= P_SEQ;
      cyc(20);
      chk("component", seq_comp, CP_1IN8);
      chk("seq on", seq_on, 24'h1);
      cyc(15000 * TK - 100);
      chk("component", seq_comp, CP_1IN8);
      cyc(200);
      chk("component", seq_comp, CP_3IN24);
      cyc(15000 * TK);
      chk("component", seq_comp, CP_1IN8);
      results();
   end

   // Tests need about 85000 cycles
   initial begin
      repeat (95000) @(posedge core_clk);
      n_fail++;
      results();
   end
endmodule : plar_core_tb

// [tb/plar_far_end.sv]
// Far-end equipment model that sends loop codes toward the block
`timescale 1ns/1ps
module plar_far_end (
   // Clock
   input wire logic core_clk,
   // Commands from the bench
   input wire plar_pkg::plar_code_t code,
   input wire logic oob,
   input wire logic up,
   input wire logic dn,
   // Programmable code, leftmost bit in bit 4
   input wire logic [4:0] pgm,
   // Line side
   output plar_pkg::plar_rx_t rx_det,
   output logic rx_bit,
   output logic rx_bit_en
);
   import plar_pkg::*;
   logic [3:0] div_r = 4'h0;
   always_ff @(posedge core_clk) begin
      div_r <= div_r + 4'h1;
   end
   logic [2:0] ph_r = 3'h0;
   logic pgm_on;
   assign pgm_on = up && (code == C_USER);
   always_ff @(posedge core_clk) begin
      if (rx_bit_en)
         ph_r <= (ph_r == 3'h4) ? 3'h0 : ph_r + 3'h1;
   end
   // programmable code repeated in band
   // Alternating payload bits never repeat with a loop-code period
   assign rx_bit = pgm_on ? pgm[3'h4 - ph_r] : div_r[3];
   assign rx_bit_en = (div_r[2:0] == 3'h0);
   // flags held as levels while the code is sent
   always_comb begin
      rx_det = '0;
      if (up || dn) begin
         rx_det.code = code;
         rx_det.inb_up = up & ~oob;
         rx_det.inb_dn = dn & ~oob;
         rx_det.oob_up = up & oob;
         rx_det.oob_dn = dn & oob;
      end
   end
endmodule : plar_far_end
